// File: design/qcp_regs.svh
// register offsets, field codes and timing constants of the counter block
`ifndef QCP_REGS_SVH
`define QCP_REGS_SVH
// ======================================================================
// register offsets (byte addresses, one word each), except QCP_A_HIGH_WIN: address bits 7:5 of the eight high time words
`define QCP_A_MODE0 8'h00
`define QCP_A_MODE1 8'h04
`define QCP_A_DIV0 8'h08
`define QCP_A_DIV1 8'h0c
`define QCP_A_CLEAR 8'h10
`define QCP_A_COUNT0 8'h14
`define QCP_A_COUNT1 8'h18
`define QCP_A_STATUS 8'h1c
`define QCP_A_HIGH_WIN 3'h1
`define QCP_A_PER0 8'h40
`define QCP_A_PER1 8'h44
`define QCP_A_STOP 8'h48
`define QCP_A_TONE_FREQ 8'h4c
`define QCP_A_TONE_GO 8'h50
// ======================================================================
// counting mode codes
`define QCP_M_BOTH 2'h0
`define QCP_M_QUAD 2'h1
`define QCP_M_RISE 2'h2
`define QCP_M_FALL 2'h3
// ======================================================================
// reset values and timing
`define QCP_RST16 16'h0000
`define QCP_CLK_HZ 32'h0098_9680
`define QCP_TONE_MIN 16'h0002
`define QCP_DIV_TOP 5'h1f
`endif

// File: design/qcp_pkg.sv
// types shared by the counter channel, its interface and the top module
package qcp_pkg;
   // counting mode field
   typedef logic [1:0] qcp_mode_type;
   // tone period calculation states
   typedef enum logic {QCP_IDLE, QCP_DIVIDE} qcp_tone_st_type;
   // state of one counter channel
   typedef struct packed {
      logic a_s1;
      logic a_s2;
      logic a_p;
      logic b_s1;
      logic b_s2;
      logic b_p;
      logic [15:0] acc;
      logic [15:0] count;
   } qcp_chan_st_type;
   // state of the top module
   typedef struct packed {
      logic [1:0][1:0] mode;
      logic [1:0][15:0] div;
      logic [7:0][15:0] high;
      logic [1:0][15:0] period;
      logic [1:0][15:0] phase;
      logic [7:0] run;
      logic [7:0] tone;
      logic [31:0] freq;
      qcp_tone_st_type tst;
      logic [2:0] tch;
      logic [4:0] bit_i;
      logic [32:0] rem;
      logic [31:0] quo;
      logic [31:0] rdata;
   } qcp_top_st_type;
endpackage

// File: design/qcp_cnt_if.sv
// control and count signals between the top and one counter channel
`timescale 1ns/1ps
interface qcp_cnt_if;
   import qcp_pkg::*;
   qcp_mode_type mode;
   logic [15:0] divider;
   logic clear;
   logic [15:0] count;
   modport ctrl (output mode, output divider, output clear, input count);
   modport chan (input mode, input divider, input clear, output count);
endinterface

// File: design/qcp_chan.sv
// one 16-bit pulse or quadrature counter channel with prescaler
`timescale 1ns/1ps
`include "qcp_regs.svh"
module qcp_chan (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // field inputs
   input wire logic phase_a_in,
   input wire logic phase_b_in,
   // control from the register file
   qcp_cnt_if.chan cnt_bus
);
   import qcp_pkg::*;
   qcp_chan_st_type q;
   qcp_chan_st_type d;
   logic step;
   logic up;

   // synchronise, detect edges, prescale and count
   always_comb begin
      d = q;
      d.a_s1 = phase_a_in;
      d.a_s2 = q.a_s1; // RQ19
      d.a_p = q.a_s2;
      d.b_s1 = phase_b_in;
      d.b_s2 = q.b_s1; // RQ19
      d.b_p = q.b_s2;
      up = 1'b1;
      case (cnt_bus.mode)
         `QCP_M_BOTH: step = q.a_s2 ^ q.a_p; // RQ1
         `QCP_M_RISE: step = q.a_s2 & ~q.a_p; // RQ1
         `QCP_M_FALL: step = ~q.a_s2 & q.a_p; // RQ1
         `QCP_M_QUAD: begin
            // one phase moves at a time; a double move is ignored
            step = (q.a_s2 ^ q.a_p) ^ (q.b_s2 ^ q.b_p); // RQ2
            up = q.a_s2 ^ q.b_p; // RQ2
         end
         default: step = 1'b0;
      endcase
      if (cnt_bus.clear) begin
         d.count = `QCP_RST16;
         d.acc = `QCP_RST16; // RQ20
      end else if (step) begin
         if (q.acc >= cnt_bus.divider) begin
            d.acc = `QCP_RST16; // RQ8
            // wraps modulo 2^16 both ways
            d.count = up ? q.count + 16'h0001 : q.count - 16'h0001; // RQ5
         end else begin
            d.acc = q.acc + 16'h0001; // RQ8
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign cnt_bus.count = q.count; // RQ6

   // count moves by exactly one step, wrapping
   property p_step;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !cnt_bus.clear && $past(q.count) != q.count && !$past(cnt_bus.clear)
      |-> (q.count == $past(q.count) + 16'h0001) ||
          (q.count == $past(q.count) - 16'h0001);
   endproperty
   a_step: assert property (p_step) else $error("count jumped"); // RQ5
   // prescale accumulator restarts after a clear
   property p_acc;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      cnt_bus.clear |=> q.acc == 16'h0000 && q.count == 16'h0000;
   endproperty
   a_acc: assert property (p_acc) else $error("clear missed"); // RQ20
endmodule

// File: design/qcp_wave.sv
// one wave channel: high while the group phase is below its high time
`timescale 1ns/1ps
module qcp_wave (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // settings and shared group phase
   input wire logic run_in,
   input wire logic [15:0] high_in,
   input wire logic [15:0] phase_in,
   // pulse output
   output logic wave_out
);
   typedef struct packed {
      logic out;
   } qcp_wave_st_type;
   qcp_wave_st_type q;
   qcp_wave_st_type d;

   // compare the phase against the high time
   always_comb begin
      d.out = run_in && (phase_in < high_in); // RQ12
   end

   // state register
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign wave_out = q.out;
endmodule

// File: design/qcp_top.sv
// two-channel counter with eight-channel grouped wave generator
//
// Summary of operation
// [RQ1] basic modes count both, rising or falling
// [RQ2] mode one counts quadrature up or down
// [RQ3] basic modes leave phase B unconnected
// [RQ4] writing mode clears the channel count
// [RQ5] sixteen-bit count wraps both directions
// [RQ6] reads return live count without stalling
// [RQ7] count reads as two's complement value
// [RQ8] count steps after divide plus one pulses
// [RQ9] divide setting resets to zero
// [RQ10] writing divide clears the channel count
// [RQ11] clear command zeroes count, keeps settings
// [RQ12] wave period and high time as programmed
// [RQ13] host keeps high time below period
// [RQ14] wave starts on configure, stops on stop
// [RQ15] eight wave channels, two period groups
// [RQ16] output frequency is clock over period
// [RQ17] one tone channel per group
// [RQ18] tone is wave output, same stop
// [RQ19] phase inputs pass two synchroniser stages
// [RQ20] clearing the count clears the prescaler
`timescale 1ns/1ps
`include "qcp_regs.svh"
module qcp_top (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   // counter field inputs
   input wire logic phase_a_ch0_in,
   input wire logic phase_b_ch0_in,
   input wire logic phase_a_ch1_in,
   input wire logic phase_b_ch1_in,
   // wave outputs
   output logic [7:0] wave_out
);
   import qcp_pkg::*;

   // ===================================================================
   // reset release
   logic rst_s1;
   logic rst_n;

   // release the asynchronous reset through two flops
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ===================================================================
   // state and channel wiring
   localparam logic [31:0] NUM = `QCP_CLK_HZ;
   qcp_top_st_type q;
   qcp_top_st_type d;
   logic [1:0] clr;
   logic [1:0][15:0] cnt;
   logic [1:0] pha;
   logic [1:0] phb;
   logic [32:0] rem_n;
   logic [31:0] quo_n;
   logic [15:0] per_n;

   assign pha = {phase_a_ch1_in, phase_a_ch0_in};
   assign phb = {phase_b_ch1_in, phase_b_ch0_in};

   qcp_cnt_if cnt_bus [2] ();

   // one counter channel per phase pair
   for (genvar g = 0; g < 2; g++) begin : g_cnt
      assign cnt_bus[g].mode = q.mode[g];
      assign cnt_bus[g].divider = q.div[g];
      assign cnt_bus[g].clear = clr[g];
      assign cnt[g] = cnt_bus[g].count;
      qcp_chan u_chan (
         .sys_clk_in(sys_clk_in),
         .rst_n_in(rst_n),
         .phase_a_in(pha[g]),
         .phase_b_in(phb[g]),
         .cnt_bus(cnt_bus[g])
      );
   end

   // one wave channel per output, four to a period group
   for (genvar i = 0; i < 8; i++) begin : g_wave
      qcp_wave u_wave (
         .sys_clk_in(sys_clk_in),
         .rst_n_in(rst_n),
         .run_in(q.run[i]),
         .high_in(q.high[i]),
         .phase_in(q.phase[i / 4]), // RQ15
         .wave_out(wave_out[i])
      );
   end

   // ===================================================================
   // next-state logic
   always_comb begin
      d = q;
      clr = 2'b00;
      d.rdata = 32'h0000_0000;
      rem_n = 33'h0_0000_0000;
      quo_n = q.quo;
      per_n = `QCP_RST16;

      // group phase runs from zero to period minus one
      for (int g = 0; g < 2; g++) begin
         if ({1'b0, q.phase[g]} + 17'h0_0001 >= {1'b0, q.period[g]}) begin
            d.phase[g] = `QCP_RST16; // RQ16
         end else begin
            d.phase[g] = q.phase[g] + 16'h0001; // RQ12
         end
      end

      // tone period: clock rate over frequency, one quotient bit a cycle
      if (q.tst == QCP_DIVIDE) begin
         rem_n = {q.rem[31:0], NUM[q.bit_i]};
         if (rem_n >= {1'b0, q.freq}) begin
            rem_n = rem_n - {1'b0, q.freq};
            quo_n[q.bit_i] = 1'b1;
         end
         d.rem = rem_n;
         d.quo = quo_n;
         d.bit_i = q.bit_i - 5'h01;
         if (q.bit_i == 5'h00) begin
            // clip the period into the sixteen-bit range
            if (quo_n[31:16] != 16'h0000) begin
               per_n = 16'hffff;
            end else if (quo_n[15:0] < `QCP_TONE_MIN) begin
               per_n = `QCP_TONE_MIN;
            end else begin
               per_n = quo_n[15:0];
            end
            // an older tone in the same group gives way
            for (int k = 0; k < 8; k++) begin
               if (k[2] == q.tch[2] && q.tone[k]) begin
                  d.run[k] = 1'b0; // RQ17
                  d.tone[k] = 1'b0; // RQ17
               end
            end
            d.period[q.tch[2]] = per_n; // RQ18
            d.high[q.tch] = {1'b0, per_n[15:1]}; // RQ18
            d.run[q.tch] = 1'b1;
            d.tone[q.tch] = 1'b1;
            d.tst = QCP_IDLE;
         end
      end

      // register writes
      if (wr_in) begin
         case (addr_in)
            `QCP_A_MODE0, `QCP_A_MODE1: begin
               d.mode[addr_in[2]] = wdata_in[1:0];
               clr[addr_in[2]] = 1'b1; // RQ4
            end
            `QCP_A_DIV0, `QCP_A_DIV1: begin
               d.div[addr_in[2]] = wdata_in[15:0]; // RQ8
               clr[addr_in[2]] = 1'b1; // RQ10
            end
            `QCP_A_CLEAR: begin
               clr = wdata_in[1:0]; // RQ11
            end
            `QCP_A_PER0, `QCP_A_PER1: begin
               d.period[addr_in[2]] = wdata_in[15:0]; // RQ15
            end
            `QCP_A_STOP: begin
               d.run = d.run & ~wdata_in[7:0]; // RQ14
               d.tone = d.tone & ~wdata_in[7:0]; // RQ18
            end
            `QCP_A_TONE_FREQ: begin
               d.freq = wdata_in;
            end
            `QCP_A_TONE_GO: begin
               // a request while a division runs is dropped
               if (q.tst == QCP_IDLE) begin
                  d.tch = wdata_in[2:0];
                  d.tst = QCP_DIVIDE;
                  d.rem = 33'h0_0000_0000;
                  d.quo = 32'h0000_0000;
                  d.bit_i = `QCP_DIV_TOP;
               end
            end
            default: begin
               // high time write starts that channel at once
               if (addr_in[7:5] == `QCP_A_HIGH_WIN) begin
                  d.high[addr_in[4:2]] = wdata_in[15:0]; // RQ12
                  d.run[addr_in[4:2]] = 1'b1; // RQ14
                  d.tone[addr_in[4:2]] = 1'b0;
               end
            end
         endcase
      end

      // register reads, data valid the following cycle
      if (rd_in) begin
         case (addr_in)
            `QCP_A_MODE0, `QCP_A_MODE1: begin
               d.rdata = {30'h0000_0000, q.mode[addr_in[2]]};
            end
            `QCP_A_DIV0, `QCP_A_DIV1: begin
               d.rdata = {16'h0000, q.div[addr_in[2]]};
            end
            `QCP_A_COUNT0: begin
               d.rdata = {16'h0000, cnt[0]}; // RQ6
            end
            `QCP_A_COUNT1: begin
               d.rdata = {16'h0000, cnt[1]}; // RQ7
            end
            `QCP_A_STATUS: begin
               d.rdata = {15'h0000, q.tst == QCP_DIVIDE, q.tone, q.run};
            end
            `QCP_A_PER0, `QCP_A_PER1: begin
               d.rdata = {16'h0000, q.period[addr_in[2]]};
            end
            `QCP_A_TONE_FREQ: begin
               d.rdata = q.freq;
            end
            default: begin
               if (addr_in[7:5] == `QCP_A_HIGH_WIN) begin
                  d.rdata = {16'h0000, q.high[addr_in[4:2]]};
               end
            end
         endcase
      end
   end

   // ===================================================================
   // state register
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0; // RQ9
      end else begin
         q <= d;
      end
   end

   assign rdata_out = q.rdata;

   // ===================================================================
   // checks
   property p_mode_clear;
      @(posedge sys_clk_in) disable iff (!rst_n)
      wr_in && addr_in == `QCP_A_MODE0 |=> cnt[0] == 16'h0000;
   endproperty
   a_mode_clear: assert property (p_mode_clear) // RQ4
      else $error("mode write kept count");

   property p_div_clear;
      @(posedge sys_clk_in) disable iff (!rst_n)
      wr_in && addr_in == `QCP_A_DIV1 |=> cnt[1] == 16'h0000 &&
         q.div[1] == $past(wdata_in[15:0]);
   endproperty
   a_div_clear: assert property (p_div_clear) // RQ10
      else $error("divide write kept count");

   property p_clear_keeps;
      @(posedge sys_clk_in) disable iff (!rst_n)
      wr_in && addr_in == `QCP_A_CLEAR && wdata_in[0]
      |=> cnt[0] == 16'h0000 && $stable(q.mode[0]) && $stable(q.div[0]);
   endproperty
   a_clear_keeps: assert property (p_clear_keeps) // RQ11
      else $error("clear lost count or settings");

   property p_div_reset;
      @(posedge sys_clk_in) disable iff (!rst_n)
      !$past(rst_n) |-> q.div[0] == 16'h0000 && q.div[1] == 16'h0000;
   endproperty
   a_div_reset: assert property (p_div_reset) // RQ9
      else $error("divide not zero after reset");

   property p_read_count;
      @(posedge sys_clk_in) disable iff (!rst_n)
      rd_in && addr_in == `QCP_A_COUNT1
      |=> rdata_out == {16'h0000, $past(cnt[1])};
   endproperty
   a_read_count: assert property (p_read_count) // RQ6
      else $error("count read wrong");

   property p_stop;
      @(posedge sys_clk_in) disable iff (!rst_n)
      wr_in && addr_in == `QCP_A_STOP && wdata_in[0]
      |=> !q.run[0] ##1 !wave_out[0];
   endproperty
   a_stop: assert property (p_stop) // RQ14
      else $error("wave kept running after stop");

   property p_phase_wrap;
      @(posedge sys_clk_in) disable iff (!rst_n)
      {1'b0, q.phase[0]} + 17'h0_0001 >= {1'b0, q.period[0]}
      |=> q.phase[0] == 16'h0000;
   endproperty
   a_phase_wrap: assert property (p_phase_wrap) // RQ16
      else $error("group phase failed to wrap");

   property p_wave_high;
      @(posedge sys_clk_in) disable iff (!rst_n)
      q.run[3] && q.phase[0] < q.high[3] |=> wave_out[3];
   endproperty
   a_wave_high: assert property (p_wave_high) // RQ12
      else $error("wave low during high time");

   property p_tone_one;
      @(posedge sys_clk_in) disable iff (!rst_n)
      $onehot0(q.tone[3:0]) && $onehot0(q.tone[7:4]);
   endproperty
   a_tone_one: assert property (p_tone_one) // RQ17
      else $error("two tones in one group");

   property p_tone_done;
      @(posedge sys_clk_in) disable iff (!rst_n)
      q.tst == QCP_DIVIDE && q.bit_i == 5'h00 && !wr_in
      |=> q.tone[$past(q.tch)] && q.run[$past(q.tch)];
   endproperty
   a_tone_done: assert property (p_tone_done) // RQ18
      else $error("tone did not start");

   // main scenarios
   c_count_wrap: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
      cnt[1] == 16'hffff ##1 cnt[1] == 16'h0000);
   c_tone: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
      q.tst == QCP_DIVIDE ##1 q.tst == QCP_IDLE);
   c_wave: cover property (@(posedge sys_clk_in) disable iff (!rst_n)
      $rose(wave_out[0]));
endmodule

// File: dv/qcp_field_src.sv
// field pulse and encoder source for the two counter channels
`timescale 1ns/1ps
module qcp_field_src #(
   parameter logic [1:0] QUAD_MASK = 2'b10
) (
   // clock
   input wire logic clk_in,
   // field lines
   output logic [1:0] phase_a_out,
   output logic [1:0] phase_b_out
);
   int pos [2];
   logic [1:0] qb;
   logic [1:0] b_q;
   // idle levels at time zero
   initial begin
      pos = '{0, 0};
      phase_a_out = 2'h0;
      qb = 2'h0;
      b_q = 2'h0;
   end
   // an open phase B line floats, shown as a level that moves every cycle
   always @(posedge clk_in) begin
      b_q <= ~b_q;
   end
   assign phase_b_out = (QUAD_MASK & qb) | (~QUAD_MASK & b_q);
   // drive phase A to a level and hold it three cycles
   task hold_a(input int ch, input logic lv);
      @(posedge clk_in);
      phase_a_out[ch] <= lv;
      repeat (2) @(posedge clk_in);
   endtask
   // whole pulses on phase A: one rise then one fall each
   task pulse(input int ch, input int n);
      repeat (n) begin
         hold_a(ch, 1'b1);
         hold_a(ch, 1'b0);
      end
   endtask
   // encoder steps, AB 00,10,11,01 going up, one line moves per step
   task step(input int ch, input int n, input bit up);
      repeat (n) begin
         pos[ch] = up ? (pos[ch] + 1) % 4 : (pos[ch] + 3) % 4;
         @(posedge clk_in);
         phase_a_out[ch] <= (pos[ch] == 1 || pos[ch] == 2);
         qb[ch] <= (pos[ch] >= 2);
         repeat (2) @(posedge clk_in);
      end
   endtask
endmodule

// File: dv/test_quadrature_counter_pwm.sv
// self-checking bench for the counter and wave block
`timescale 1ns/1ps
`include "qcp_regs.svh"
module test_quadrature_counter_pwm;
   logic sys_clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [31:0] rdata_out;
   logic [7:0] wave_out;
   logic [1:0] pa;
   logic [1:0] pb;
   logic [31:0] v;
   logic [1:0] modes [3] = '{`QCP_M_BOTH, `QCP_M_RISE, `QCP_M_FALL};
   logic [31:0] exps [3] = '{32'h6, 32'h3, 32'h3};
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int hi;

   qcp_top dut (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .phase_a_ch0_in(pa[0]),
      .phase_b_ch0_in(pb[0]),
      .phase_a_ch1_in(pa[1]),
      .phase_b_ch1_in(pb[1]),
      .wave_out(wave_out)
   );
   qcp_field_src src (
      .clk_in(sys_clk_in),
      .phase_a_out(pa),
      .phase_b_out(pb)
   );

   // 10 MHz clock
   initial begin
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   // cut a hang short well past the expected run length
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         results();
      end
   end
   // ======================================================================
   // register port tasks
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask
   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask
   task rchk(input string name, input logic [7:0] a, input logic [31:0] e);
      rd(a, v);
      chk(name, e, v);
   endtask
   // let the synchroniser and detector settle, then read
   task cchk(input string name, input logic [7:0] a, input logic [31:0] e);
      repeat (6) @(posedge sys_clk_in);
      rchk(name, a, e);
   endtask
   // high cycles of one wave line over 40 cycles
   task wchk(input string name, input int n, input int e);
      hi = 0;
      repeat (8) @(posedge sys_clk_in);
      repeat (40) begin
         @(posedge sys_clk_in);
         #1 if (wave_out[n] === 1'b1) hi++;
      end
      chk(name, e, hi);
   endtask
   task results;
      if (bad_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ======================================================================
   // main sequence
   initial begin
      repeat (16) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      rchk("count0", `QCP_A_COUNT0, 32'h0);
      rchk("status", `QCP_A_STATUS, 32'h0);
      rchk("unmapped", 8'hfc, 32'h0);
      // each basic mode, the mode write clearing the last count
      for (int i = 0; i < 3; i++) begin
         wr(`QCP_A_MODE0, {30'h0, modes[i]});
         rchk("mode clear", `QCP_A_COUNT0, 32'h0);
         src.pulse(0, 3);
         cchk("basic", `QCP_A_COUNT0, exps[i]);
      end
      // encoder on channel 1, wrapping both ways
      wr(`QCP_A_MODE1, 32'h1);
      src.step(1, 5, 1'b1);
      cchk("quad up", `QCP_A_COUNT1, 32'h5);
      src.step(1, 7, 1'b0);
      cchk("quad down", `QCP_A_COUNT1, 32'hfffe);
      src.step(1, 3, 1'b1);
      cchk("quad wrap", `QCP_A_COUNT1, 32'h1);
      rchk("open b", `QCP_A_COUNT0, 32'h3);
      // divider, clear command and prescale accumulator
      wr(`QCP_A_DIV0, 32'h2);
      rchk("div clear", `QCP_A_COUNT0, 32'h0);
      src.pulse(0, 5);
      cchk("divided", `QCP_A_COUNT0, 32'h1);
      wr(`QCP_A_CLEAR, 32'h1);
      rchk("clear", `QCP_A_COUNT0, 32'h0);
      rchk("other kept", `QCP_A_COUNT1, 32'h1);
      // divider on the encoder channel, stepping down through zero
      wr(`QCP_A_DIV1, 32'h1);
      rchk("div1 clear", `QCP_A_COUNT1, 32'h0);
      rchk("div1", `QCP_A_DIV1, 32'h1);
      rchk("mode1", `QCP_A_MODE1, 32'h1);
      src.step(1, 4, 1'b0);
      cchk("quad div", `QCP_A_COUNT1, 32'hfffe);
      src.pulse(0, 1);
      cchk("acc clear", `QCP_A_COUNT0, 32'h0);
      src.pulse(0, 2);
      cchk("div kept", `QCP_A_COUNT0, 32'h1);
      wr(`QCP_A_DIV0, 32'h0);
      src.pulse(0, 1);
      cchk("div one", `QCP_A_COUNT0, 32'h1);
      // grouped wave channels, high time kept below period
      wr(`QCP_A_PER0, 32'ha);
      wr(`QCP_A_PER1, 32'h8);
      wr(8'h20, 32'h3);
      wr(8'h24, 32'h5);
      wr(8'h30, 32'h2);
      wchk("wave0", 0, 12);
      wchk("wave1", 1, 20);
      wchk("wave4", 4, 10);
      rchk("run", `QCP_A_STATUS, 32'h13);
      wr(`QCP_A_STOP, 32'h3);
      wchk("stop0", 0, 0);
      wchk("stop1", 1, 0);
      wchk("still", 4, 10);
      // tone on group 0, then moved to another channel of the group
      wr(`QCP_A_TONE_FREQ, 32'h000f4240);
      wr(`QCP_A_TONE_GO, 32'h2);
      repeat (40) @(posedge sys_clk_in);
      rchk("tone st", `QCP_A_STATUS, 32'h0414);
      wchk("tone2", 2, 20);
      wr(`QCP_A_TONE_FREQ, 32'h001e8480);
      wr(`QCP_A_TONE_GO, 32'h3);
      repeat (40) @(posedge sys_clk_in);
      rchk("tone swap", `QCP_A_STATUS, 32'h0818);
      rchk("tone per", `QCP_A_PER0, 32'h5);
      rchk("tone high", 8'h2c, 32'h2);
      rchk("freq", `QCP_A_TONE_FREQ, 32'h001e8480);
      // read data stand one cycle only, then fall back to zero
      @(posedge sys_clk_in);
      #1 chk("rdata idle", 32'h0, rdata_out);
      wchk("old tone", 2, 0);
      wchk("tone3", 3, 16);
      wchk("group1", 4, 10);
      wr(`QCP_A_STOP, 32'h8);
      wchk("tone stop", 3, 0);
      rd(`QCP_A_STATUS, v);
      chk("run left", 32'h10, {24'h0, v[7:0]});
      results();
   end
endmodule
